//--- dv/addr_gen_unit_tb.sv
`timescale 1ns/1ps
module addr_gen_unit_tb;
	import agu_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic xr = 1'b0;
	logic yr = 1'b0;
	logic pr = 1'b0;
	logic en = 1'b0;
	logic sp = 1'b0;
	logic fl = 1'b0;
	logic [4:0] sel = 5'h00;
	logic [1:0] lx = 2'h0;
	logic [1:0] hx = 2'h0;
	word_t wd = 16'h0000;
	upd_op_t lo = OP_NONE;
	upd_op_t ho = OP_NONE;
	bus_src_t xs = SRC_LOW;
	bus_src_t ys = SRC_LOW;
	bus_src_t ps = SRC_LOW;
	word_t rdat;
	word_t xdata_addr_bus;
	word_t ydata_addr_bus;
	word_t program_addr_bus;
	logic xv;
	logic yv;
	logic pv;
	logic [7:0] hits;
	int err_count = 0;
	int check_count = 0;
	word_t eb [7] = '{16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h0110, 16'h00FF};
	word_t er [7] = '{16'h0100, 16'h0101, 16'h00FF, 16'h0110, 16'h00F0, 16'h0100, 16'h00FF};
	always #5 clk = ~clk;
	addr_gen_unit dut_u
	(
		.I_SYS_CLK(clk), .I_RST(rst), .I_CE(ce), .I_GDB_WR(wr), .I_GDB_RD(rd),
		.I_GDB_SEL(sel), .I_GDB_WDATA(wd), .O_GDB_RDATA(rdat), .I_LO_OP(lo), .I_LO_IDX(lx),
		.I_HI_OP(ho), .I_HI_IDX(hx), .I_XAB_REQ(xr), .I_XAB_SRC(xs), .I_YAB_REQ(yr),
		.I_YAB_SRC(ys), .I_PAB_REQ(pr), .I_PAB_SRC(ps), .I_STK_EXT_EN(en),
		.I_STK_SPILL(sp), .I_STK_FILL(fl), .O_XAB(xdata_addr_bus), .O_XAB_VALID(xv), .O_YAB(ydata_addr_bus),
		.O_YAB_VALID(yv), .O_PAB(program_addr_bus), .O_PAB_VALID(pv)
	);
	addr_mem_model mem_u
	(
		.i_clk(clk), .i_rst(rst), .i_xv(xv), .i_yv(yv), .i_pv(pv), .o_hits(hits)
	);
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input word_t s, input word_t e);
		check_count++;
		if (s !== e)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc;
		@(posedge clk);
		#1;
	endtask
	// drop every request, then let one edge pass
	task automatic fin;
		wr = 1'b0;
		rd = 1'b0;
		lo = OP_NONE;
		ho = OP_NONE;
		xr = 1'b0;
		yr = 1'b0;
		pr = 1'b0;
		sp = 1'b0;
		fl = 1'b0;
		cyc();
	endtask
	task automatic wreg(input logic [1:0] g, input logic [2:0] x, input word_t d);
		sel = {g, x};
		wd = d;
		wr = 1'b1;
		cyc();
		fin();
	endtask
	task automatic rreg(input logic [1:0] g, input logic [2:0] x, input word_t e);
		sel = {g, x};
		rd = 1'b1;
		cyc();
		chk("rdata", rdat, e);
		fin();
	endtask
	task automatic trip(input logic [2:0] x, input word_t r, input word_t n, input word_t m);
		wreg(2'h0, x, r);
		wreg(2'h1, x, n);
		wreg(2'h2, x, m);
	endtask
	task automatic lupd(input logic [1:0] x, input upd_op_t o);
		lx = x;
		lo = o;
		cyc();
		fin();
	endtask
	task automatic t_regs;
		for (int i = 0; i < 8; i++)
		begin
			rreg(2'h0, 3'(i), 16'h0000);
			rreg(2'h1, 3'(i), 16'h0000);
			rreg(2'h2, 3'(i), 16'hFFFF);
			wreg(2'h0, 3'(i), 16'(16'hC000 + i));
			rreg(2'h0, 3'(i), 16'(16'hC000 + i));
			wreg(2'h1, 3'(i), 16'(16'h0A00 + i));
			rreg(2'h1, 3'(i), 16'(16'h0A00 + i));
			wreg(2'h2, 3'(i), 16'(16'h7F00 + i));
			rreg(2'h2, 3'(i), 16'(16'h7F00 + i));
			wreg(2'h2, 3'(i), 16'hFFFF);
		end
		wreg(2'h3, 3'h1, 16'h1234);
		rreg(2'h3, 3'h1, 16'h0000);
	endtask
	task automatic t_ops;
		wreg(2'h1, 3'h5, 16'h0010);
		for (int i = 0; i < 7; i++)
		begin
			wreg(2'h0, 3'h5, 16'h0100);
			hx = 2'h1;
			ho = upd_op_t'(i);
			yr = 1'b1;
			ys = SRC_HIGH;
			cyc();
			chk("yab", ydata_addr_bus, eb[i]);
			chk("yv", word_t'(yv), 16'h0001);
			fin();
			rreg(2'h0, 3'h5, er[i]);
		end
	endtask
	task automatic t_arith;
		trip(3'h0, 16'hFFFE, 16'h0003, 16'hFFFF);
		lx = 2'h0;
		lo = OP_POST_ADD_N;
		xr = 1'b1;
		xs = SRC_LOW;
		cyc();
		chk("xab", xdata_addr_bus, 16'hFFFE);
		fin();
		rreg(2'h0, 3'h0, 16'h0001);
		rreg(2'h0, 3'h1, 16'hC001);
		trip(3'h1, 16'h0004, 16'h0000, 16'h0004);
		lupd(2'h1, OP_POST_INC);
		rreg(2'h0, 3'h1, 16'h0000);
		lupd(2'h1, OP_POST_DEC);
		rreg(2'h0, 3'h1, 16'h0004);
		trip(3'h2, 16'h0000, 16'h0008, 16'h0000);
		lupd(2'h2, OP_POST_ADD_N);
		lupd(2'h2, OP_POST_ADD_N);
		rreg(2'h0, 3'h2, 16'h0004);
		trip(3'h3, 16'h0006, 16'h0003, 16'h8007);
		lupd(2'h3, OP_POST_ADD_N);
		rreg(2'h0, 3'h3, 16'h0001);
	endtask
	task automatic t_dual;
		logic [7:0] h;
		trip(3'h0, 16'h0020, 16'h0000, 16'hFFFF);
		trip(3'h4, 16'h0040, 16'h0000, 16'hFFFF);
		h = hits;
		lx = 2'h0;
		lo = OP_POST_INC;
		hx = 2'h0;
		ho = OP_POST_DEC;
		xr = 1'b1;
		yr = 1'b1;
		cyc();
		chk("xab", xdata_addr_bus, 16'h0020);
		chk("yab", ydata_addr_bus, 16'h0040);
		fin();
		rreg(2'h0, 3'h0, 16'h0021);
		rreg(2'h0, 3'h4, 16'h003F);
		pr = 1'b1;
		ps = SRC_HIGH;
		xr = 1'b1;
		yr = 1'b1;
		cyc();
		chk("pab", program_addr_bus, 16'h003F);
		chk("pv", word_t'(pv), 16'h0001);
		chk("xyv", word_t'({xv, yv}), 16'h0000);
		fin();
		chk("hits", word_t'(8'(hits - h)), 16'h0003);
	endtask
	task automatic t_stk;
		wreg(2'h3, 3'h0, 16'h1234);
		en = 1'b1;
		sp = 1'b1;
		cyc();
		chk("xab", xdata_addr_bus, 16'h1234);
		cyc();
		chk("xab", xdata_addr_bus, 16'h1235);
		sp = 1'b0;
		fl = 1'b1;
		cyc();
		chk("xab", xdata_addr_bus, 16'h1235);
		fin();
		rreg(2'h3, 3'h0, 16'h1235);
		en = 1'b0;
		sp = 1'b1;
		cyc();
		chk("xv", word_t'(xv), 16'h0000);
		fin();
		ce = 1'b0;
		lo = OP_POST_INC;
		cyc();
		ce = 1'b1;
		fin();
		rreg(2'h0, 3'h0, 16'h0021);
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		cyc();
		t_regs();
		t_ops();
		t_arith();
		t_dual();
		t_stk();
		close_out();
	end
	initial
	begin
		#200000;
		err_count++;
		close_out();
	end
endmodule

//--- dv/addr_mem_model.sv
`timescale 1ns/1ps
module addr_mem_model
(
	input wire logic i_clk, // clock
	input wire logic i_rst, // reset
	input wire logic i_xv, // x access
	input wire logic i_yv, // y access
	input wire logic i_pv, // program access
	output logic [7:0] o_hits // accesses seen
);
	// memory side counts each bus access it is offered
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			o_hits <= 8'h00;
		else
			o_hits <= o_hits + 8'(i_xv) + 8'(i_yv) + 8'(i_pv);
	end
endmodule

//--- dv/agu_asserts.sv
`timescale 1ns/1ps
module agu_asserts
(
	input wire logic I_SYS_CLK,
	input wire logic I_RST,
	input wire logic I_CE,
	input wire logic I_GDB_WR,
	input wire logic I_GDB_RD,
	input wire logic [4:0] I_GDB_SEL,
	input wire agu_pkg::word_t I_GDB_WDATA,
	input wire agu_pkg::word_t O_GDB_RDATA,
	input wire logic I_XAB_REQ,
	input wire logic I_PAB_REQ,
	input wire logic I_STK_EXT_EN,
	input wire logic I_STK_SPILL,
	input wire logic I_STK_FILL,
	input wire agu_pkg::word_t O_XAB,
	input wire logic O_XAB_VALID,
	input wire logic O_YAB_VALID,
	input wire logic O_PAB_VALID
);
	import agu_pkg::*;
	logic stk;
	logic spl;
	assign stk = I_CE && I_STK_EXT_EN && (I_STK_SPILL || I_STK_FILL);
	assign spl = I_CE && I_STK_EXT_EN && I_STK_SPILL && !I_GDB_WR;
	default clocking @(posedge I_SYS_CLK);
	endclocking
	default disable iff (I_RST);
	x_req_valid_a: assert property (I_CE && I_XAB_REQ && !I_PAB_REQ |=> O_XAB_VALID)
		else $error("x valid missing");
	x_idle_a: assert property (I_CE && !I_XAB_REQ && !stk |=> !O_XAB_VALID)
		else $error("x valid unasked");
	pab_excl_a: assert property (I_CE && I_PAB_REQ && !stk |=> O_PAB_VALID && !O_XAB_VALID
		&& !O_YAB_VALID) else $error("p not exclusive");
	stk_own_a: assert property (stk |=> O_XAB_VALID)
		else $error("stack x missing");
	stk_step_a: assert property (spl ##1 spl |=> O_XAB == $past(O_XAB) + 16'h0001)
		else $error("spill step");
	stk_fill_a: assert property (spl ##1 (stk && !I_STK_SPILL && !I_GDB_WR)
		|=> O_XAB == $past(O_XAB)) else $error("fill step");
	rd_back_a: assert property (I_CE && I_GDB_WR && I_GDB_SEL[4:3] == 2'h1 ##1 !I_GDB_WR
		##1 I_CE && I_GDB_RD && !I_GDB_WR && I_GDB_SEL == $past(I_GDB_SEL, 2)
		|=> O_GDB_RDATA == $past(I_GDB_WDATA, 3)) else $error("read back");
	rsv_zero_a: assert property (I_CE && I_GDB_RD && I_GDB_SEL[4:3] == 2'h3
		&& I_GDB_SEL[2:0] != 3'h0 |=> O_GDB_RDATA == 16'h0000) else $error("reserved read");
endmodule
bind addr_gen_unit agu_asserts chk_u
(
	.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_CE(I_CE), .I_GDB_WR(I_GDB_WR),
	.I_GDB_RD(I_GDB_RD), .I_GDB_SEL(I_GDB_SEL), .I_GDB_WDATA(I_GDB_WDATA),
	.O_GDB_RDATA(O_GDB_RDATA), .I_XAB_REQ(I_XAB_REQ), .I_PAB_REQ(I_PAB_REQ),
	.I_STK_EXT_EN(I_STK_EXT_EN), .I_STK_SPILL(I_STK_SPILL), .I_STK_FILL(I_STK_FILL),
	.O_XAB(O_XAB), .O_XAB_VALID(O_XAB_VALID), .O_YAB_VALID(O_YAB_VALID),
	.O_PAB_VALID(O_PAB_VALID)
);

//--- hw/addr_alu_half.sv
`timescale 1ns/1ps
`include "agu_params.svh"
module addr_alu_half
(
	input wire agu_pkg::word_t i_addr, // selected address register
	input wire agu_pkg::word_t i_offset, // paired offset register
	input wire agu_pkg::word_t i_modifier, // paired modifier register
	input wire agu_pkg::upd_op_t i_op, // addressing mode
	output agu_pkg::word_t o_ea, // effective address
	output agu_pkg::word_t o_new_addr, // updated address
	output logic o_we // write back the update
);
	import agu_pkg::*;

	word_t step;
	word_t off_sum;
	word_t rev_sum;
	word_t mask;
	word_t base;
	word_t mod_sum;
	word_t wrap_sum;
	word_t result;
	logic [`AGU_DATA_WIDTH:0] rel_sum;
	logic [`AGU_DATA_WIDTH:0] mod_rel;
	logic [`AGU_DATA_WIDTH:0] modulus;
	arith_t arith;

	always_comb
	begin
		case (i_op)
			OP_POST_INC: step = `AGU_STEP_ONE;
			OP_POST_DEC, OP_PRE_DEC: step = `AGU_STEP_MINUS_ONE;
			OP_POST_SUB_N: step = word_t'(~i_offset + `AGU_STEP_ONE);
			default: step = i_offset;
		endcase
	end

	assign arith = decode_arith(i_modifier);
	assign off_sum = word_t'(i_addr + step);
	assign rev_sum = bit_rev(word_t'(bit_rev(i_addr) + bit_rev(step)));

	// modulo window is the power-of-two block holding the address
	assign mask = (arith == AR_MODULO) ? mod_mask(i_modifier) :
		mod_mask({1'b0, i_modifier[`AGU_DATA_WIDTH-2:0]});
	assign base = i_addr & ~mask;
	assign modulus = {1'b0, i_modifier};
	assign rel_sum = {1'b0, i_addr & mask} + {step[`AGU_DATA_WIDTH-1], step};

	always_comb
	begin
		mod_rel = rel_sum;
		if (rel_sum[`AGU_DATA_WIDTH])
			mod_rel = rel_sum + modulus + 17'h00001;
		else if (rel_sum > modulus)
			mod_rel = rel_sum - modulus - 17'h00001;
	end

	assign mod_sum = base | (mod_rel[`AGU_DATA_WIDTH-1:0] & mask);
	assign wrap_sum = base | (off_sum & mask);

	always_comb
	begin
		case (arith)
			AR_MODULO: result = mod_sum;
			AR_MULTI_WRAP: result = wrap_sum;
			AR_REVERSE: result = rev_sum;
			default: result = off_sum;
		endcase
	end

	// pre-update and indexed modes present the computed address
	assign o_ea = (i_op == OP_PRE_DEC || i_op == OP_INDEX_N) ? result : i_addr;
	assign o_new_addr = result;
	assign o_we = (i_op != OP_NONE) && (i_op != OP_INDEX_N);
endmodule

//--- hw/addr_gen_unit.sv
`timescale 1ns/1ps
`include "agu_params.svh"
module addr_gen_unit #(
	parameter int DW = `AGU_DATA_WIDTH,
	parameter int NTRIP = `AGU_TRIPLETS_PER_HALF
)
(
	input wire logic I_SYS_CLK, // core instruction clock
	input wire logic I_RST, // async reset, active high
	input wire logic I_CE, // clock enable, freezes state when low
	input wire logic I_GDB_WR, // data bus register write strobe
	input wire logic I_GDB_RD, // data bus register read strobe
	input wire logic [`AGU_SEL_WIDTH-1:0] I_GDB_SEL, // register select
	input wire agu_pkg::word_t I_GDB_WDATA, // write data
	output agu_pkg::word_t O_GDB_RDATA, // read data, registered
	input wire agu_pkg::upd_op_t I_LO_OP, // low half addressing mode
	input wire logic [1:0] I_LO_IDX, // low half triplet 0-3
	input wire agu_pkg::upd_op_t I_HI_OP, // high half addressing mode
	input wire logic [1:0] I_HI_IDX, // high half triplet 4-7
	input wire logic I_XAB_REQ, // x data address wanted
	input wire agu_pkg::bus_src_t I_XAB_SRC, // x address source half
	input wire logic I_YAB_REQ, // y data address wanted
	input wire agu_pkg::bus_src_t I_YAB_SRC, // y address source half
	input wire logic I_PAB_REQ, // program address wanted
	input wire agu_pkg::bus_src_t I_PAB_SRC, // program address source half
	input wire logic I_STK_EXT_EN, // stack extension enabled
	input wire logic I_STK_SPILL, // hardware stack spills one word
	input wire logic I_STK_FILL, // hardware stack fills one word
	output agu_pkg::word_t O_XAB, // x data address bus
	output logic O_XAB_VALID, // x address valid
	output agu_pkg::word_t O_YAB, // y data address bus
	output logic O_YAB_VALID, // y address valid
	output agu_pkg::word_t O_PAB, // program address bus
	output logic O_PAB_VALID // program address valid
);
	import agu_pkg::*;

	localparam int NREG = 2 * NTRIP;
	localparam int IDXW = $clog2(NTRIP);
	localparam int SELW = `AGU_SEL_WIDTH;

	// triplet storage, index 0..3 low half, 4..7 high half
	word_t address_pointer [0:NREG-1];
	word_t step_offset_reg [0:NREG-1];
	word_t arith_modifier_reg [0:NREG-1];
	word_t stack_spill_pointer;

	upd_op_t half_op [0:1];
	logic [IDXW-1:0] half_idx [0:1];
	word_t half_ea [0:1];
	word_t half_new [0:1];
	logic half_we [0:1];
	logic [NREG-1:0] upd_we;
	word_t upd_val [0:NREG-1];

	reg_grp_t gdb_grp;
	logic [`AGU_SEL_IDX_MSB:0] gdb_idx;
	logic stk_access;
	logic stk_spill;
	logic stk_fill;
	word_t stk_addr;
	word_t next_stack_spill_pointer;
	word_t next_rdata;

	function automatic logic [`AGU_SEL_IDX_MSB:0] global_idx(input int h,
		input logic [IDXW-1:0] idx);
		return (`AGU_SEL_IDX_MSB+1)'(h * NTRIP + int'(idx));
	endfunction

	function automatic logic gdb_hit(input logic wr, input reg_grp_t grp,
		input reg_grp_t want, input logic [`AGU_SEL_IDX_MSB:0] idx, input int i);
		return wr && (grp == want) && (int'(idx) == i);
	endfunction

	assign gdb_grp = reg_grp_t'(I_GDB_SEL[`AGU_SEL_GRP_MSB:`AGU_SEL_GRP_LSB]);
	assign gdb_idx = I_GDB_SEL[`AGU_SEL_IDX_MSB:`AGU_SEL_IDX_LSB];

	assign half_op[0] = I_LO_OP;
	assign half_op[1] = I_HI_OP;
	assign half_idx[0] = I_LO_IDX;
	assign half_idx[1] = I_HI_IDX;

	// each half sees only the triplet it selects
	generate
		for (genvar h = 0; h < 2; h++)
		begin : g_half
			logic [`AGU_SEL_IDX_MSB:0] gi;
			assign gi = global_idx(h, half_idx[h]);
			addr_alu_half u_alu
			(
				.i_addr(address_pointer[gi]),
				.i_offset(step_offset_reg[gi]),
				.i_modifier(arith_modifier_reg[gi]),
				.i_op(half_op[h]),
				.o_ea(half_ea[h]),
				.o_new_addr(half_new[h]),
				.o_we(half_we[h])
			);
		end
	endgenerate

	// at most one write-back per half per cycle
	always_comb
	begin
		for (int i = 0; i < NREG; i++)
		begin
			upd_we[i] = 1'b0;
			upd_val[i] = half_new[i / NTRIP];
			if (half_we[i / NTRIP] && (int'(half_idx[i / NTRIP]) == i % NTRIP))
				upd_we[i] = 1'b1;
		end
	end

	// address registers; a bus write wins over an update to the same one
	always_ff @(posedge I_SYS_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			for (int i = 0; i < NREG; i++)
				address_pointer[i] <= `AGU_ADDR_RESET;
		end
		else if (I_CE)
		begin
			for (int i = 0; i < NREG; i++)
			begin
				if (gdb_hit(I_GDB_WR, gdb_grp, GRP_ADDR, gdb_idx, i))
					address_pointer[i] <= I_GDB_WDATA;
				else if (upd_we[i])
					address_pointer[i] <= upd_val[i];
			end
		end
	end

	always_ff @(posedge I_SYS_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			for (int i = 0; i < NREG; i++)
				step_offset_reg[i] <= `AGU_OFFSET_RESET;
		end
		else if (I_CE)
		begin
			for (int i = 0; i < NREG; i++)
			begin
				if (gdb_hit(I_GDB_WR, gdb_grp, GRP_OFFSET, gdb_idx, i))
					step_offset_reg[i] <= I_GDB_WDATA;
			end
		end
	end

	always_ff @(posedge I_SYS_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			for (int i = 0; i < NREG; i++)
				arith_modifier_reg[i] <= `AGU_MOD_RESET;
		end
		else if (I_CE)
		begin
			for (int i = 0; i < NREG; i++)
			begin
				if (gdb_hit(I_GDB_WR, gdb_grp, GRP_MODIFIER, gdb_idx, i))
					arith_modifier_reg[i] <= I_GDB_WDATA;
			end
		end
	end

	// stack extension: spill posts increment, fill pre-decrements
	assign stk_access = I_STK_EXT_EN && (I_STK_SPILL || I_STK_FILL);
	assign stk_spill = I_STK_EXT_EN && I_STK_SPILL;
	assign stk_fill = I_STK_EXT_EN && I_STK_FILL && !I_STK_SPILL;
	assign stk_addr = stk_fill ? word_t'(stack_spill_pointer - `AGU_STEP_ONE) :
		stack_spill_pointer;

	always_comb
	begin
		next_stack_spill_pointer = stack_spill_pointer;
		if (gdb_hit(I_GDB_WR, gdb_grp, GRP_STACK, gdb_idx, 0))
			next_stack_spill_pointer = I_GDB_WDATA;
		else if (stk_spill)
			next_stack_spill_pointer = word_t'(stack_spill_pointer + `AGU_STEP_ONE);
		else if (stk_fill)
			next_stack_spill_pointer = stk_addr;
	end

	// deliberately no reset: software loads it before enabling the extension
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_CE)
			stack_spill_pointer <= next_stack_spill_pointer;
	end

	// register read path
	always_comb
	begin
		next_rdata = O_GDB_RDATA;
		if (I_GDB_RD)
		begin
			if (gdb_grp == GRP_ADDR)
				next_rdata = address_pointer[gdb_idx];
			else if (gdb_grp == GRP_OFFSET)
				next_rdata = step_offset_reg[gdb_idx];
			else if (gdb_grp == GRP_MODIFIER)
				next_rdata = arith_modifier_reg[gdb_idx];
			else if (gdb_idx == '0)
				next_rdata = stack_spill_pointer;
			else
				next_rdata = `AGU_RDATA_RESET;
		end
	end

	always_ff @(posedge I_SYS_CLK or posedge I_RST)
	begin
		if (I_RST)
			O_GDB_RDATA <= `AGU_RDATA_RESET;
		else if (I_CE)
			O_GDB_RDATA <= next_rdata;
	end

	// x bus: stack traffic first, then data unless a program fetch is out
	always_ff @(posedge I_SYS_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			O_XAB <= `AGU_ADDR_RESET;
			O_XAB_VALID <= 1'b0;
		end
		else if (I_CE)
		begin
			O_XAB_VALID <= 1'b0;
			if (stk_access)
			begin
				O_XAB <= stk_addr;
				O_XAB_VALID <= 1'b1;
			end
			else if (I_XAB_REQ && !I_PAB_REQ)
			begin
				O_XAB <= half_ea[I_XAB_SRC];
				O_XAB_VALID <= 1'b1;
			end
		end
	end

	// y bus; distinct halves for x and y are the issuer's duty
	always_ff @(posedge I_SYS_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			O_YAB <= `AGU_ADDR_RESET;
			O_YAB_VALID <= 1'b0;
		end
		else if (I_CE)
		begin
			O_YAB_VALID <= 1'b0;
			if (I_YAB_REQ && !I_PAB_REQ)
			begin
				O_YAB <= half_ea[I_YAB_SRC];
				O_YAB_VALID <= 1'b1;
			end
		end
	end

	always_ff @(posedge I_SYS_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			O_PAB <= `AGU_ADDR_RESET;
			O_PAB_VALID <= 1'b0;
		end
		else if (I_CE)
		begin
			O_PAB_VALID <= 1'b0;
			if (I_PAB_REQ)
			begin
				O_PAB <= half_ea[I_PAB_SRC];
				O_PAB_VALID <= 1'b1;
			end
		end
	end
endmodule

//--- hw/agu_params.svh
// Function
// - linear, modulo, multi-wrap and reverse-carry updates
// - two identical halves, four triplets each
// - 16-bit offset adder: +1, -1, +N, -N
// - modulo adder applies plus or minus modulus
// - reverse-carry adder, carries run MSB to LSB
// - adders run in parallel, selector picks sum
// - one update per half per cycle, modifier-decoded
// - two addresses: X plus Y, or program
// - each address bus spans 65536 locations
// - triplets 0-3 low half, 4-7 high
// - address updated only by own triplet
// - all triplet registers read/write over data bus
// - output muxes route low or high address
// - eight 16-bit address registers, pointer or data
// - pre or post update per addressing mode
// - read, modify, write back same register
// - stack pointer addresses memory on spill/fill
// - stack pointer readable, writable, implicitly stepped
// - stack pointer not reset; software loads it
// - modifiers reset to all ones, linear
// - modifier value also gives the modulus
// - eight 16-bit offset registers, offset or data
`ifndef AGU_PARAMS_SVH
`define AGU_PARAMS_SVH

`define AGU_DATA_WIDTH 16
`define AGU_TRIPLETS_PER_HALF 4

// register select on the data bus: group in [4:3], index in [2:0]
`define AGU_SEL_WIDTH 5
`define AGU_SEL_GRP_MSB 4
`define AGU_SEL_GRP_LSB 3
`define AGU_SEL_IDX_MSB 2
`define AGU_SEL_IDX_LSB 0
`define AGU_GRP_ADDR 2'h0
`define AGU_GRP_OFFSET 2'h1
`define AGU_GRP_MODIFIER 2'h2
`define AGU_GRP_STACK 2'h3

`define AGU_ADDR_RESET 16'h0000
`define AGU_OFFSET_RESET 16'h0000
`define AGU_MOD_RESET 16'hFFFF
`define AGU_MOD_LINEAR 16'hFFFF
`define AGU_MOD_REVERSE 16'h0000
`define AGU_MOD_WRAP_TAG 2'h2
`define AGU_RDATA_RESET 16'h0000
`define AGU_STEP_ONE 16'h0001
`define AGU_STEP_MINUS_ONE 16'hFFFF

`endif

//--- hw/agu_pkg.sv
`include "agu_params.svh"
package agu_pkg;
	typedef logic [`AGU_DATA_WIDTH-1:0] word_t;

	typedef enum logic [2:0]
	{
		OP_NONE = 3'h0,
		OP_POST_INC = 3'h1,
		OP_POST_DEC = 3'h2,
		OP_POST_ADD_N = 3'h3,
		OP_POST_SUB_N = 3'h4,
		OP_INDEX_N = 3'h5,
		OP_PRE_DEC = 3'h6
	} upd_op_t;

	typedef enum logic [1:0]
	{
		AR_LINEAR = 2'h0,
		AR_MODULO = 2'h1,
		AR_MULTI_WRAP = 2'h2,
		AR_REVERSE = 2'h3
	} arith_t;

	typedef enum logic
	{
		SRC_LOW = 1'b0,
		SRC_HIGH = 1'b1
	} bus_src_t;

	typedef enum logic [1:0]
	{
		GRP_ADDR = `AGU_GRP_ADDR,
		GRP_OFFSET = `AGU_GRP_OFFSET,
		GRP_MODIFIER = `AGU_GRP_MODIFIER,
		GRP_STACK = `AGU_GRP_STACK
	} reg_grp_t;

	function automatic word_t bit_rev(input word_t v);
		word_t r;
		r = '0;
		for (int i = 0; i < `AGU_DATA_WIDTH; i++)
		begin
			r[i] = v[`AGU_DATA_WIDTH-1-i];
		end
		return r;
	endfunction

	// smallest 2^k-1 covering lim
	function automatic word_t mod_mask(input word_t lim);
		word_t mk;
		mk = lim;
		for (int s = 1; s < `AGU_DATA_WIDTH; s = s * 2)
		begin
			mk = mk | (mk >> s);
		end
		return mk;
	endfunction

	function automatic arith_t decode_arith(input word_t m);
		arith_t a;
		a = AR_LINEAR;
		if (m == `AGU_MOD_LINEAR)
			a = AR_LINEAR;
		else if (m == `AGU_MOD_REVERSE)
			a = AR_REVERSE;
		else if (!m[`AGU_DATA_WIDTH-1])
			a = AR_MODULO;
		else if (m[`AGU_DATA_WIDTH-1:`AGU_DATA_WIDTH-2] == `AGU_MOD_WRAP_TAG)
			a = AR_MULTI_WRAP;
		return a;
	endfunction
endpackage
